/* include/exec_pkg.sv */
// constants for the move, branch and call execution group
package exec_pkg;
	localparam int PC_W       = 10;
	localparam int DATA_W     = 8;
	localparam int FILE_AW    = 6;
	localparam int SFR_AW     = 4;
	localparam int OP_W       = 3;
	localparam int STACK_AW   = 3;

	// opcode select codes
	localparam logic [OP_W-1:0] OP_NOP         = 3'h0;
	localparam logic [OP_W-1:0] OP_SPECIAL_WR  = 3'h1;
	localparam logic [OP_W-1:0] OP_CALL        = 3'h2;
	localparam logic [OP_W-1:0] OP_JUMP        = 3'h3;
	localparam logic [OP_W-1:0] OP_LOAD_IMM    = 3'h4;
	localparam logic [OP_W-1:0] OP_ACC_STORE   = 3'h5;
	localparam logic [OP_W-1:0] OP_REG_MOVE    = 3'h6;

	// cycle counts per instruction
	localparam int CYC_SHORT  = 1;
	localparam int CYC_BRANCH = 2;

	// destination select of the register move
	localparam logic DEST_ACC  = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// reset values
	localparam logic [PC_W-1:0]     PC_RST   = 10'h000;
	localparam logic [DATA_W-1:0]   ACC_RST  = 8'h00;
	localparam logic [STACK_AW-1:0] SP_RST   = 3'h0;
	localparam logic                ZERO_RST = 1'b0;

	typedef enum logic [1:0] {
		ST_EXEC  = 2'b01,
		ST_FLUSH = 2'b10
	} exec_state_t;
endpackage

/* rtl/move_branch_exec.sv */
// execution unit for special write, call, jump, immediate load and moves
//
// Function
// RULE_01: special_page_write copies the accumulator into secondary-page register 0..15 in one cycle, flags untouched.
// RULE_02: subroutine_call pushes the current program counter plus one on the stack top and bumps the stack pointer.
// RULE_03: subroutine_call then loads its 10-bit target into program counter bits 9..0, taking two cycles.
// RULE_04: unconditional_jump loads its 10-bit target into the program counter in two cycles, stack and flags untouched.
// RULE_05: load_immediate puts its 8-bit operand in the accumulator in one cycle, flags untouched.
// RULE_06: accumulator_store copies the accumulator to data-file register 0..63 in one cycle, accumulator kept.
// RULE_07: register_move reads register 0..63 and writes it to the accumulator (select 0) or back (select 1) in one cycle.
// RULE_08: register_move sets the zero flag when the moved value is zero and clears it otherwise.
// RULE_09: call and jump discard the already fetched next instruction and spend their second cycle as a no-operation.
`timescale 1ns/10ps
module move_branch_exec #(
	parameter int STACK_AW = exec_pkg::STACK_AW
) (
	input  wire logic                         mclk_in,       // core clock, 100 MHz
	input  wire logic                         rst_in,        // synchronous reset, high
	input  wire logic                         instr_valid_in, // fetched instruction present
	input  wire logic [exec_pkg::OP_W-1:0]    opcode_in,     // decoded operation select
	input  wire logic [exec_pkg::PC_W-1:0]    operand_in,    // immediate, address or target
	input  wire logic                         dest_sel_in,   // register move destination
	input  wire logic [exec_pkg::FILE_AW-1:0] peek_addr_in,  // data-file observe address
	output logic      [exec_pkg::DATA_W-1:0]  acc_out,       // accumulator
	output logic                              zero_out,      // zero flag
	output logic      [exec_pkg::PC_W-1:0]    pc_out,        // program counter
	output logic      [STACK_AW-1:0]          stack_ptr_out, // stack level
	output logic      [exec_pkg::PC_W-1:0]    stack_top_out, // last pushed address
	output logic                              flush_out,     // discard cycle in progress
	output logic                              sfr_wr_out,    // special register write pulse
	output logic      [exec_pkg::SFR_AW-1:0]  sfr_addr_out,  // special register index
	output logic      [exec_pkg::DATA_W-1:0]  sfr_data_out,  // special register data
	output logic      [exec_pkg::DATA_W-1:0]  peek_data_out  // data-file observe value
);
	localparam int DEPTH = 1 << STACK_AW;

	exec_pkg::exec_state_t state_reg, state_next;
	logic [exec_pkg::DATA_W-1:0] acc_reg, acc_next;
	logic                        zero_reg, zero_next;
	logic [exec_pkg::PC_W-1:0]   pc_reg, pc_next;
	logic [STACK_AW-1:0]         sp_reg, sp_next;
	logic                        push;
	logic                        file_we;
	logic [exec_pkg::DATA_W-1:0] file_wdata;
	logic                        sfr_wr_next;
	logic [exec_pkg::DATA_W-1:0] data_file [0:63];
	logic [exec_pkg::PC_W-1:0]   stack_mem [0:DEPTH-1];
	logic [exec_pkg::DATA_W-1:0] file_rd;
	logic                        take;
	logic [exec_pkg::PC_W-1:0]   pc_inc;
	logic [STACK_AW-1:0]         sp_after;
	logic [exec_pkg::PC_W-1:0]   stack_top_reg, stack_top_next;
	logic                        flush_reg, flush_next;

	// one adder serves both the sequential step and the return address
	function automatic logic [exec_pkg::PC_W-1:0] next_pc(input logic [exec_pkg::PC_W-1:0] pc);
		next_pc = pc + 10'h001;
	endfunction

	assign take      = instr_valid_in && (state_reg == exec_pkg::ST_EXEC);
	assign file_rd   = data_file[operand_in[exec_pkg::FILE_AW-1:0]];
	assign pc_inc    = next_pc(pc_reg);

	// next-state decode for all execution state
	always_comb begin
		state_next  = exec_pkg::ST_EXEC;
		acc_next    = acc_reg;
		zero_next   = zero_reg;
		pc_next     = pc_reg;
		sp_next     = sp_reg;
		push        = 1'b0;
		file_we     = 1'b0;
		file_wdata  = acc_reg;
		sfr_wr_next = 1'b0;
		case (state_reg)
			exec_pkg::ST_EXEC: begin
				if (take) begin
					pc_next = pc_inc;
					case (opcode_in)
						exec_pkg::OP_SPECIAL_WR: begin
							sfr_wr_next = 1'b1; // [RULE_01]
						end
						exec_pkg::OP_CALL: begin
							push       = 1'b1; // [RULE_02]
							sp_next    = sp_reg + STACK_AW'(1); // [RULE_02]
							pc_next    = operand_in; // [RULE_03]
							state_next = exec_pkg::ST_FLUSH; // [RULE_09]
						end
						exec_pkg::OP_JUMP: begin
							pc_next    = operand_in; // [RULE_04]
							state_next = exec_pkg::ST_FLUSH; // [RULE_09]
						end
						exec_pkg::OP_LOAD_IMM: begin
							acc_next = operand_in[exec_pkg::DATA_W-1:0]; // [RULE_05]
						end
						exec_pkg::OP_ACC_STORE: begin
							file_we = 1'b1; // [RULE_06]
						end
						exec_pkg::OP_REG_MOVE: begin
							zero_next = (file_rd == 8'h00); // [RULE_08]
							if (dest_sel_in == exec_pkg::DEST_FILE) begin
								file_we    = 1'b1; // [RULE_07]
								file_wdata = file_rd;
							end else begin
								acc_next = file_rd; // [RULE_07]
							end
						end
						default: begin
							pc_next = pc_inc;
						end
					endcase
				end
			end
			// fetched word is dropped, nothing executes this cycle
			exec_pkg::ST_FLUSH: begin
				state_next = exec_pkg::ST_EXEC; // [RULE_09]
			end
			default: begin
				state_next = exec_pkg::ST_EXEC;
			end
		endcase
		// top copy kept in a flop so the port has no memory read path
		sp_after       = rst_in ? STACK_AW'(exec_pkg::SP_RST) : sp_next;
		stack_top_next = (push && !rst_in) ? pc_inc : stack_mem[sp_after - STACK_AW'(1)];
		flush_next     = !rst_in && (state_next == exec_pkg::ST_FLUSH);
	end

	// control state registers
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_reg <= exec_pkg::ST_EXEC;
			acc_reg   <= exec_pkg::ACC_RST;
			zero_reg  <= exec_pkg::ZERO_RST;
			pc_reg    <= exec_pkg::PC_RST;
			sp_reg    <= exec_pkg::SP_RST;
		end else begin
			state_reg <= state_next;
			acc_reg   <= acc_next;
			zero_reg  <= zero_next;
			pc_reg    <= pc_next;
			sp_reg    <= sp_next;
		end
	end

	// storage arrays; no reset, contents are undefined until written
	always_ff @(posedge mclk_in) begin
		if (!rst_in && file_we) begin
			data_file[operand_in[exec_pkg::FILE_AW-1:0]] <= file_wdata; // [RULE_06]
		end
		if (!rst_in && push) begin
			stack_mem[sp_reg] <= pc_inc; // [RULE_02]
		end
	end

	// output copies of the stack top and the discard flag
	always_ff @(posedge mclk_in) begin
		stack_top_reg <= stack_top_next; // [RULE_02]
		flush_reg     <= flush_next; // [RULE_09]
	end

	// registered side outputs; the special register page lives outside
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			sfr_wr_out    <= 1'b0;
			sfr_addr_out  <= 4'h0;
			sfr_data_out  <= 8'h00;
			peek_data_out <= 8'h00;
		end else begin
			sfr_wr_out    <= sfr_wr_next; // [RULE_01]
			sfr_addr_out  <= operand_in[exec_pkg::SFR_AW-1:0];
			sfr_data_out  <= acc_reg;
			peek_data_out <= data_file[peek_addr_in];
		end
	end

	// state outputs mirror registers directly
	assign acc_out       = acc_reg;
	assign zero_out      = zero_reg;
	assign pc_out        = pc_reg;
	assign stack_ptr_out = sp_reg;
	assign stack_top_out = stack_top_reg;
	assign flush_out     = flush_reg;

	// checks on what the block drives, one or more per rule

	a_special_wr_copy: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE_01]
		take && opcode_in == exec_pkg::OP_SPECIAL_WR |=> sfr_wr_out
		&& sfr_data_out == $past(acc_reg) && sfr_addr_out == $past(operand_in[3:0])
		&& zero_reg == $past(zero_reg) && !flush_out)
		else $error("special write did not copy accumulator");
	a_call_push_ret: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE_02]
		take && opcode_in == exec_pkg::OP_CALL |=> stack_top_reg == $past(pc_reg) + 10'h001
		&& sp_reg == $past(sp_reg) + 3'h1)
		else $error("call pushed wrong return address");
	a_call_target_load: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE_03]
		take && opcode_in == exec_pkg::OP_CALL |=> pc_reg == $past(operand_in) ##1 !flush_out)
		else $error("call target not loaded in two cycles");
	a_jump_target_load: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE_04]
		take && opcode_in == exec_pkg::OP_JUMP |=> pc_reg == $past(operand_in)
		&& $stable(sp_reg) && $stable(zero_reg))
		else $error("jump target wrong or stack touched");
	a_load_imm_acc: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE_05]
		take && opcode_in == exec_pkg::OP_LOAD_IMM |=> acc_reg == $past(operand_in[7:0])
		&& $stable(zero_reg) && pc_reg == $past(pc_reg) + 10'h001)
		else $error("immediate load wrong");
	a_acc_store_file: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE_06]
		take && opcode_in == exec_pkg::OP_ACC_STORE |=> $stable(acc_reg)
		&& data_file[$past(operand_in[5:0])] == acc_reg)
		else $error("accumulator store wrong");
	a_move_dest_sel: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE_07]
		take && opcode_in == exec_pkg::OP_REG_MOVE && dest_sel_in == exec_pkg::DEST_ACC
		|=> acc_reg == $past(file_rd))
		else $error("register move to accumulator wrong");
	a_move_file_back: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE_07]
		take && opcode_in == exec_pkg::OP_REG_MOVE && dest_sel_in == exec_pkg::DEST_FILE
		|=> data_file[$past(operand_in[5:0])] == $past(file_rd) && $stable(acc_reg))
		else $error("register move back to file wrong");
	a_move_zero_flag: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE_08]
		take && opcode_in == exec_pkg::OP_REG_MOVE |=> zero_reg == ($past(file_rd) == 8'h00))
		else $error("register move zero flag wrong");
	a_branch_flush_nop: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE_09]
		flush_out |=> !flush_out && $stable(acc_reg) && $stable(sp_reg) && $stable(pc_reg)
		&& $stable(zero_reg) && !sfr_wr_out)
		else $error("discard cycle changed state");
endmodule

/* test/tb_move_branch_exec.sv */
// self-checking bench for the move, branch and call execution unit
`timescale 1ns/10ps
module tb_move_branch_exec;
	logic        mclk_in = 0, rst_in = 1, instr_valid_in = 0, dest_sel_in = 0;
	logic [2:0]  opcode_in = 0;
	logic [9:0]  operand_in = 0;
	logic [5:0]  peek_addr_in = 0;
	logic [7:0]  acc_out, sfr_data_out, peek_data_out;
	logic        zero_out, flush_out, sfr_wr_out;
	logic [9:0]  pc_out, stack_top_out;
	logic [2:0]  stack_ptr_out;
	logic [3:0]  sfr_addr_out;
	logic [63:0] qv[$], qm[$], m0, sn, ev;
	logic [7:0]  acc, sd, fm[64];
	logic [9:0]  pc, stk[8];
	logic [2:0]  sp;
	logic [3:0]  sa;
	logic        z, fl, wr;
	bit          sv[8];
	int          fails = 0, n_checks = 0, cyc = 0, seed = 32'hd5b77c65;

	move_branch_exec u_move_branch_exec (.mclk_in(mclk_in), .rst_in(rst_in),
		.instr_valid_in(instr_valid_in), .opcode_in(opcode_in), .operand_in(operand_in),
		.dest_sel_in(dest_sel_in), .peek_addr_in(peek_addr_in), .acc_out(acc_out),
		.zero_out(zero_out), .pc_out(pc_out), .stack_ptr_out(stack_ptr_out),
		.stack_top_out(stack_top_out), .flush_out(flush_out), .sfr_wr_out(sfr_wr_out),
		.sfr_addr_out(sfr_addr_out), .sfr_data_out(sfr_data_out),
		.peek_data_out(peek_data_out));

	// 100 MHz clock
	initial begin
		forever #5 mclk_in = ~mclk_in;
	end

	task end_sim;
		if (fails == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one instruction slot: drive at the falling edge, note the expected state
	task step(input logic rs, input logic v, input logic [2:0] op,
		input logic [9:0] opd, input logic d);
		logic [7:0] pk;
		@(negedge mclk_in);
		rst_in = rs;
		instr_valid_in = v;
		opcode_in = op;
		operand_in = opd;
		dest_sel_in = d;
		peek_addr_in = 6'($random(seed));
		pk = fm[peek_addr_in];
		wr = 0;
		if (rs) begin
			{acc, z, pc, sp, fl, sa, sd, pk} = '0;
		end else if (fl) begin
			fl = 0; // fetched word discarded
		end else if (v) begin
			pc = pc + 10'h001;
			case (op)
				exec_pkg::OP_SPECIAL_WR: {wr, sa, sd} = {1'b1, opd[3:0], acc};
				exec_pkg::OP_CALL: begin
					stk[sp] = pc; // return address pushed
					sv[sp] = 1;
					sp = sp + 3'h1;
					pc = opd;
					fl = 1;
				end
				exec_pkg::OP_JUMP: {pc, fl} = {opd, 1'b1};
				exec_pkg::OP_LOAD_IMM: acc = opd[7:0];
				exec_pkg::OP_ACC_STORE: begin
					fm[opd[5:0]] = acc; // peek saw the old word at this edge
				end
				exec_pkg::OP_REG_MOVE: begin
					z = (fm[opd[5:0]] == 8'h00);
					if (!d) acc = fm[opd[5:0]]; // write-back keeps the file value
				end
				default: ;
			endcase
		end
		qv.push_back(64'({stk[sp - 3'h1], pk, sa, sd, wr, fl, sp, pc, z, acc}));
		qm.push_back(64'({{10{sv[sp - 3'h1]}}, 8'hff, {12{wr}}, 24'hffffff}));
	endtask

	// monitor: compare settled outputs against the oldest note
	always @(posedge mclk_in) begin
		#1;
		if (qv.size() != 0) begin
			m0 = qm.pop_front();
			sn = m0 & 64'({stack_top_out, peek_data_out, sfr_addr_out, sfr_data_out, sfr_wr_out,
				flush_out, stack_ptr_out, pc_out, zero_out, acc_out});
			ev = m0 & qv.pop_front();
			check(64'(sn[53:44]), 64'(ev[53:44]));
			check(64'(sn[43:36]), 64'(ev[43:36]));
			check(64'(sn[35:23]), 64'(ev[35:23]));
			check(64'(sn[22]), 64'(ev[22]));
			check(64'(sn[21:19]), 64'(ev[21:19]));
			check(64'(sn[18:9]), 64'(ev[18:9]));
			check(64'(sn[8]), 64'(ev[8]));
			check(64'(sn[7:0]), 64'(ev[7:0]));
		end
	end

	// hang guard, generous against about 2160 slots
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc > 4000) begin
			fails++;
			end_sim();
		end
	end

	// directed boundaries first, then random traffic, with a reset in mid-run
	initial begin
		repeat (4) step(1, 0, 0, 0, 0);
		for (int i = 0; i < 64; i++) begin
			step(0, 1, exec_pkg::OP_LOAD_IMM, 10'(i * 7), 0);
			step(0, 1, exec_pkg::OP_ACC_STORE, 10'(i), 0);
		end
		step(0, 1, exec_pkg::OP_LOAD_IMM, 10'h0aa, 0);
		step(0, 1, exec_pkg::OP_SPECIAL_WR, 10'h00f, 0);
		step(0, 1, exec_pkg::OP_CALL, 10'h3ff, 0);
		step(0, 1, exec_pkg::OP_LOAD_IMM, 10'h055, 0); // refused during discard
		step(0, 1, exec_pkg::OP_JUMP, 10'h000, 0);
		step(0, 1, exec_pkg::OP_ACC_STORE, 10'h001, 0); // refused during discard
		for (int i = 0; i < 9; i++) step(0, 1, exec_pkg::OP_CALL, 10'(i * 100), 0);
		step(0, 0, 0, 0, 0); // lets the last discard pass so the moves are taken
		step(0, 1, exec_pkg::OP_REG_MOVE, 10'h000, 1);
		step(0, 1, exec_pkg::OP_REG_MOVE, 10'h001, 0);
		step(0, 1, exec_pkg::OP_REG_MOVE, 10'h000, 0);
		repeat (2) step(1, 1, exec_pkg::OP_CALL, 10'h123, 0);
		repeat (2000) step(0, ($random(seed) % 5) != 0, 3'($random(seed)),
			10'($random(seed)), 1'($random(seed)));
		repeat (2) step(0, 0, 0, 0, 0);
		@(negedge mclk_in);
		end_sim();
	end
endmodule
